// ### src/dual_supply_reset_supervisor.sv
/*
 Dual supply reset supervisor: reset, power-fail flag and primary
 power-good outputs from synchronised below-threshold comparator bits.
 Assumes comparators, threshold selection and pin electrics live outside;
 all inputs are synchronous to clk, which doubles as the timebase.
*/
`timescale 1ns/1ps
module dual_supply_reset_supervisor #(
   parameter logic                                 LONG_OPTION     = 1'b0,
   parameter logic                                 HAS_SECONDARY   = 1'b1,
   parameter logic                                 HAS_AUX         = 1'b1,
   parameter logic                                 HAS_MANUAL      = 1'b1,
   parameter logic                                 HAS_PIN_DETECT  = 1'b1,
   parameter logic [1:0]                           VARIANT         =
      supervisor_pkg::VARIANT_DUAL,
   parameter logic [15:0]                          VARIANT_CODE    = 16'h0000,
   parameter logic [supervisor_pkg::CNT_W-1:0]     SHORT_CYC       =
      supervisor_pkg::CNT_W'(supervisor_pkg::SHORT_TIMEOUT_CYC),
   parameter logic [supervisor_pkg::CNT_W-1:0]     LONG_CYC        =
      supervisor_pkg::CNT_W'(supervisor_pkg::LONG_TIMEOUT_CYC),
   parameter logic [supervisor_pkg::CNT_W-1:0]     MANUAL_CYC      =
      supervisor_pkg::CNT_W'(supervisor_pkg::MANUAL_TIMEOUT_CYC),
   parameter logic [supervisor_pkg::CNT_W-1:0]     GOOD_CYC        =
      supervisor_pkg::CNT_W'(supervisor_pkg::GOOD_TIMEOUT_CYC),
   parameter logic [supervisor_pkg::CNT_W-1:0]     DEBOUNCE_CYC    =
      supervisor_pkg::CNT_W'(supervisor_pkg::DEBOUNCE_CYC)
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        primaryBelow,
   input  wire logic        secondaryBelow,
   input  wire logic        auxBelow,
   input  wire logic        powerfailBelow,
   input  wire logic        manual_reset_in_n,
   input  wire logic        resetPinIn,
   output logic             resetOut_n,
   output logic             resetOe,
   output logic             powerfail_flag_n,
   output logic             primary_supply_good,
   output logic [1:0]       variantKind,
   output logic [15:0]      variantCode
);
   localparam int unsigned W = supervisor_pkg::CNT_W;

   typedef enum logic [2:0] {
      ST_HOLD    = 3'h1,
      ST_TIMING  = 3'h2,
      ST_RUN     = 3'h4
   } rst_state_t;

   logic       syncA_reg;
   logic       syncB_reg;
   logic       rstSyncN;
   logic       manualFilt;
   logic       pinLowDeb;
   logic       supplyDone;
   logic       manualDone;
   logic       goodDone;
   logic       supplyFault;
   logic       manualActive;
   logic       pinActive;
   logic       pinLowRaw;
   rst_state_t state_reg;
   rst_state_t state_next;
   logic       rst_reg;
   logic       rst_next;
   logic       pf_reg;
   logic       pf_next;
   logic       good_reg;
   logic       good_next;
   logic       pinHeld_reg;
   logic       pinHeld_next;
   logic       oe_reg;
   logic       oe_next;
   logic [W-1:0] supplyLen;

   // Reset release through two flops; async assert, clocked release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syncA_reg <= 1'b0;
         syncB_reg <= 1'b0;
      end else begin
         syncA_reg <= 1'b1;
         syncB_reg <= syncA_reg;
      end
   end
   assign rstSyncN = syncB_reg;

   // Monitored supply fault; absent monitors never fault
   assign supplyFault = primaryBelow
                      | (HAS_SECONDARY & secondaryBelow)
                      | (HAS_AUX & auxBelow);
   assign supplyLen = LONG_OPTION ? LONG_CYC : SHORT_CYC;

   // Manual input filtered so short glitches never start a reset
   glitch_filter #(
      .LEN  (supervisor_pkg::GLITCH_FILTER_CYC),
      .W    (supervisor_pkg::FILT_W),
      .INIT (1'b1)
   ) u_manual_filt (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .rawIn    (manual_reset_in_n),
      .filtOut  (manualFilt)
   );
   assign manualActive = HAS_MANUAL & ~manualFilt;

   // Pin pulled low while we are not driving it means an external pulldown.
   // Only seen while released; during our own drive the pin reads low anyway.
   assign pinLowRaw = HAS_PIN_DETECT & rst_reg & ~resetPinIn;
   glitch_filter #(
      .LEN  (DEBOUNCE_CYC),
      .W    (W),
      .INIT (1'b0)
   ) u_pin_deb (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .rawIn    (pinLowRaw),
      .filtOut  (pinLowDeb)
   );
   // Held until pinLowDeb has dropped and the pin is seen high; we stop driving meanwhile so
   // the release can be seen. The pin may read high a cycle before redrive.
   assign pinActive = pinHeld_reg;

   // Supply timeout restarts on every drop
   hold_timer #(.W(W)) u_supply_tmr (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .clear    (supplyFault),
      .len      (supplyLen),
      .done     (supplyDone)
   );

   // Manual timeout is always MANUAL_CYC, whatever LONG_OPTION selects
   hold_timer #(.W(W)) u_manual_tmr (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .clear    (manualActive | pinActive),
      .len      (MANUAL_CYC),
      .done     (manualDone)
   );

   // Power-good timer sees only the primary comparison
   hold_timer #(.W(W)) u_good_tmr (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .clear    (primaryBelow),
      .len      (GOOD_CYC),
      .done     (goodDone)
   );

   // Reset sequencer; faults force HOLD ahead of any timer state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_HOLD: begin
            if (!supplyFault && !manualActive && !pinActive) begin
               state_next = ST_TIMING;
            end
         end
         ST_TIMING: begin
            if (supplyFault || manualActive || pinActive) begin
               state_next = ST_HOLD;
            end else if (supplyDone && manualDone) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (supplyFault || manualActive || pinActive) begin
               state_next = ST_HOLD;
            end
         end
         default: state_next = ST_HOLD;
      endcase
      rst_next = (state_next == ST_RUN);
      // Set wins over the release seen on the pin
      pinHeld_next = pinLowDeb | (pinHeld_reg & ~resetPinIn);
      oe_next      = ~rst_next & ~pinHeld_next;
   end

   // Power-fail flag has no timeout; power-good is its own timer gated by primaryBelow
   always_comb begin
      pf_next   = ~powerfailBelow;
      good_next = goodDone & ~primaryBelow;
   end

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         state_reg <= ST_HOLD;
         rst_reg   <= 1'b0;
         pf_reg    <= 1'b0;
         good_reg  <= 1'b0;
         pinHeld_reg <= 1'b0;
         oe_reg    <= 1'b1;
      end else begin
         state_reg <= state_next;
         rst_reg   <= rst_next;
         pf_reg    <= pf_next;
         good_reg  <= good_next;
         pinHeld_reg <= pinHeld_next;
         oe_reg    <= oe_next;
      end
   end

   assign resetOut_n          = rst_reg;
   assign resetOe             = oe_reg;  // Drive low only; pullup gives high
   assign powerfail_flag_n    = pf_reg;
   assign primary_supply_good = good_reg;
   // Threshold selection is static; exported for the analog side
   assign variantKind         = VARIANT;
   assign variantCode         = VARIANT_CODE;
endmodule

// ### src/glitch_filter.sv
/*
 Glitch filter: output follows input only after it has held steady for
 LEN cycles. Assumes the input is synchronous to clk.
*/
`timescale 1ns/1ps
module glitch_filter #(
   parameter int unsigned LEN   = 1,
   parameter int unsigned W     = 32,
   parameter logic        INIT  = 1'b1
) (
   input  wire logic clk,
   input  wire logic rstSyncN,
   input  wire logic rawIn,
   output logic      filtOut
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic         out_reg;
   logic         out_next;

   // Count while input differs from output; any agreement restarts the count
   always_comb begin
      cnt_next = '0;
      out_next = out_reg;
      if (rawIn != out_reg) begin
         if (cnt_reg >= W'(LEN - 1)) begin
            out_next = rawIn;
         end else begin
            cnt_next = cnt_reg + W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         cnt_reg <= '0;
         out_reg <= INIT;
      end else begin
         cnt_reg <= cnt_next;
         out_reg <= out_next;
      end
   end

   assign filtOut = out_reg;
endmodule

// ### src/hold_timer.sv
/*
 Hold timer: done goes high once clear has been low for LEN consecutive
 cycles; any cycle with clear high restarts from zero.
*/
`timescale 1ns/1ps
module hold_timer #(
   parameter int unsigned W = 32
) (
   input  wire logic         clk,
   input  wire logic         rstSyncN,
   input  wire logic         clear,
   input  wire logic [W-1:0] len,
   output logic              done
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic         done_reg;
   logic         done_next;

   // Restart on clear, saturate once the length is reached
   always_comb begin
      cnt_next  = cnt_reg;
      done_next = done_reg;
      if (clear) begin
         cnt_next  = '0;
         done_next = 1'b0;
      end else if (cnt_reg >= len - W'(1)) begin
         done_next = 1'b1;
      end else begin
         cnt_next = cnt_reg + W'(1);
      end
   end

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         cnt_reg  <= '0;
         done_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         done_reg <= done_next;
      end
   end

   assign done = done_reg;
endmodule

// ### src/supervisor_pkg.sv
/*
 Constants for the dual supply reset supervisor: clock rate, timeouts,
 debounce and glitch figures, and the cycle counts derived from them.
 Assumes a 40 MHz system clock acting as the internal timebase.
*/
package supervisor_pkg;
   // Timebase
   localparam int unsigned CLK_HZ              = 40000000;
   localparam int unsigned CLK_PERIOD_NS       = 25;
   // Times as printed, in their own units
   localparam int unsigned SHORT_TIMEOUT_MS    = 150;   // Short supply option, least
   localparam int unsigned LONG_TIMEOUT_MS     = 1200;  // Long supply option, least
   localparam int unsigned MANUAL_TIMEOUT_MS   = 150;   // Manual reset timeout, least
   localparam int unsigned GOOD_TIMEOUT_US     = 37500; // Power-good timeout, least
   localparam int unsigned DEBOUNCE_US         = 37500; // Pin pulldown debounce, least
   localparam int unsigned MIN_PULSE_NS        = 1000;  // Manual reset minimum pulse
   localparam int unsigned GLITCH_NS           = 100;   // Rejected glitch width
   // Counts in clock cycles; least times round up
   localparam int unsigned CYC_PER_MS          = CLK_HZ / 1000;
   localparam int unsigned SHORT_TIMEOUT_CYC   = SHORT_TIMEOUT_MS * CYC_PER_MS;
   localparam int unsigned LONG_TIMEOUT_CYC    = LONG_TIMEOUT_MS * CYC_PER_MS;
   localparam int unsigned MANUAL_TIMEOUT_CYC  = MANUAL_TIMEOUT_MS * CYC_PER_MS;
   localparam int unsigned GOOD_TIMEOUT_CYC    = (GOOD_TIMEOUT_US * (CLK_HZ / 1000000));
   localparam int unsigned DEBOUNCE_CYC        = (DEBOUNCE_US * (CLK_HZ / 1000000));
   // Glitch filter must accept 1 us but reject 100 ns: pick 550 ns worth
   localparam int unsigned GLITCH_FILTER_CYC   =
      ((MIN_PULSE_NS + GLITCH_NS) / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W               = 32;
   localparam int unsigned FILT_W              = 8;
   // Variant codes for the threshold pair; arbitrary labels
   localparam logic [1:0] VARIANT_DUAL         = 2'h0;
   localparam logic [1:0] VARIANT_SINGLE       = 2'h1;
endpackage

// ### testbench/cpu_reset_partner.sv
/* Far side of the reset pin: a processor reset input and a pushbutton
   to ground. Assumes the pin has a pull-up. */
`timescale 1ns/1ps
module cpu_reset_partner (
   input  wire logic resetOe,
   input  wire logic pressBtn,
   output logic      pinLevel,
   output logic      cpuHeld
);
   // Pull-up wins unless the supervisor or the button sinks the pin
   assign pinLevel = !(resetOe || pressBtn);
   // Processor stays in reset while its input is low
   assign cpuHeld = !pinLevel;
endmodule

// ### testbench/dual_supply_reset_supervisor_tb.sv
/* Self-checking bench for the supervisor with shortened timeouts.
   Assumes the pushbutton partner on the reset pin. */
`timescale 1ns/1ps
module dual_supply_reset_supervisor_tb;
   localparam logic [31:0] SHORT  = 32'h32;
   localparam logic [31:0] MANUAL = 32'h28;
   localparam logic [31:0] GOOD   = 32'h14;
   localparam logic [31:0] DEB    = 32'h1e;
   logic clk = 1'b0, rst_n = 1'b0, priB = 1'b0, secB = 1'b0, auxB = 1'b0;
   logic pfB = 1'b0, manN = 1'b1, press = 1'b0;
   logic resetOut_n, resetOe, pfFlag_n, good, pinLevel, cpuHeld;
   logic [1:0] vKind;
   logic [15:0] vCode;
   int errors = 0, num_checks = 0, n;

   // 40 MHz clock
   always #12.5 clk = ~clk;

   dual_supply_reset_supervisor #(.SHORT_CYC(SHORT), .LONG_CYC(32'h64),
      .MANUAL_CYC(MANUAL), .GOOD_CYC(GOOD), .DEBOUNCE_CYC(DEB)
   ) u_dual_supply_reset_supervisor (.clk(clk), .rst_n(rst_n), .primaryBelow(priB),
      .secondaryBelow(secB), .auxBelow(auxB), .powerfailBelow(pfB),
      .manual_reset_in_n(manN), .resetPinIn(pinLevel), .resetOut_n(resetOut_n),
      .resetOe(resetOe), .powerfail_flag_n(pfFlag_n), .primary_supply_good(good),
      .variantKind(vKind), .variantCode(vCode));

   cpu_reset_partner u_cpu_reset_partner (.resetOe(resetOe), .pressBtn(press),
      .pinLevel(pinLevel), .cpuHeld(cpuHeld));

   task automatic check_bit(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic check_rng(input string what, input int lo, input int hi, input int got);
      num_checks++;
      if (got < lo || got > hi) begin
         errors++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   // Bounded wait for reset release, or for power-good when sel is set
   task automatic wait_hi(input bit sel, output int cnt);
      cnt = 0;
      while ((sel ? good : resetOut_n) !== 1'b1 && cnt < 600) begin
         @(negedge clk);
         cnt++;
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic t_powerup;
      check_bit("reset at start", 1'b0, resetOut_n);
      wait_hi(1'b0, n);
      check_rng("first release", SHORT, SHORT + 6, n);
      check_bit("good after start", 1'b1, good);
      check_bit("variant", 1'b1, vKind === 2'h0);
      check_bit("variant code", 1'b1, vCode === 16'h0000);
      $display("powerup done");
   endtask
   task automatic t_supply;
      for (int k = 0; k < 3; k++) begin
         {auxB, secB, priB} = 3'(1 << k);
         repeat (2) @(negedge clk);
         check_bit("reset on drop", 1'b0, resetOut_n);
         {auxB, secB, priB} = 3'h0;
         repeat (25) @(negedge clk);
         {auxB, secB, priB} = 3'(1 << k);
         @(negedge clk);
         {auxB, secB, priB} = 3'h0;
         wait_hi(1'b0, n);
         check_rng("restarted timeout", SHORT, SHORT + 6, n);
      end
      $display("supply done");
   endtask
   task automatic t_manual;
      manN = 1'b0;
      repeat (4) @(negedge clk);
      manN = 1'b1;
      repeat (30) @(negedge clk);
      check_bit("glitch ignored", 1'b1, resetOut_n);
      manN = 1'b0;
      repeat (40) @(negedge clk);
      check_bit("manual held", 1'b0, resetOut_n);
      check_bit("good ignores manual", 1'b1, good);
      manN = 1'b1;
      wait_hi(1'b0, n);
      check_rng("manual timeout", MANUAL, MANUAL + 30, n);
      $display("manual done");
   endtask
   task automatic t_pf;
      pfB = 1'b1;
      @(negedge clk);
      check_bit("flag asserted", 1'b0, pfFlag_n);
      pfB = 1'b0;
      @(negedge clk);
      check_bit("flag free", 1'b1, pfFlag_n);
      check_bit("no reset on flag", 1'b1, resetOut_n);
      $display("powerfail done");
   endtask
   task automatic t_good;
      priB = 1'b1;
      @(negedge clk);
      @(negedge clk);
      check_bit("good drops", 1'b0, good);
      priB = 1'b0;
      secB = 1'b1;
      wait_hi(1'b1, n);
      check_rng("good timeout", GOOD, GOOD + 6, n);
      secB = 1'b0;
      wait_hi(1'b0, n);
      check_rng("release after second", SHORT, SHORT + 6, n);
      $display("good done");
   endtask
   task automatic t_pin;
      press = 1'b1;
      repeat (10) @(negedge clk);
      press = 1'b0;
      repeat (5) @(negedge clk);
      check_bit("short press ignored", 1'b1, resetOut_n);
      press = 1'b1;
      repeat (DEB + 30) @(negedge clk);
      check_bit("pin reset held", 1'b1, cpuHeld);
      press = 1'b0;
      wait_hi(1'b0, n);
      check_rng("pin timeout", MANUAL, MANUAL + 30, n);
      $display("pin done");
   endtask

   // Watchdog sized well past the expected run
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      t_powerup();
      t_supply();
      t_manual();
      t_pf();
      t_good();
      t_pin();
      report_and_stop();
   end
endmodule

// ### testbench/supervisor_asserts.sv
/* Checker on the supervisor top ports, bound at the foot of this file.
   Assumes one clock and the active-low asynchronous rst_n. */
`timescale 1ns/1ps
module supervisor_asserts #(
   parameter logic [31:0] SHORT_CYC  = 32'h32,
   parameter logic [31:0] MANUAL_CYC = 32'h28,
   parameter logic [31:0] GOOD_CYC   = 32'h14
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic primaryBelow,
   input wire logic secondaryBelow,
   input wire logic auxBelow,
   input wire logic powerfailBelow,
   input wire logic manual_reset_in_n,
   input wire logic resetOut_n,
   input wire logic resetOe,
   input wire logic powerfail_flag_n,
   input wire logic primary_supply_good
);
   logic [31:0] goodCnt_reg;
   logic [31:0] manLow_reg;
   logic [31:0] manHigh_reg;
   logic [31:0] priCnt_reg;
   // Run lengths seen at the pins; the design may never beat them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         goodCnt_reg <= '0;
         manLow_reg  <= '0;
         manHigh_reg <= '0;
         priCnt_reg  <= '0;
      end else begin
         goodCnt_reg <= (primaryBelow || secondaryBelow || auxBelow) ? '0 : goodCnt_reg + 1;
         manLow_reg  <= manual_reset_in_n ? '0 : manLow_reg + 1;
         // Short glitches are filtered, so only a long low restarts it
         manHigh_reg <= (manLow_reg >= 32'h16) ? '0 : manHigh_reg + 1;
         priCnt_reg  <= primaryBelow ? '0 : priCnt_reg + 1;
      end
   end

   supply_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
      (primaryBelow || secondaryBelow) |=> !resetOut_n) else $error("reset missed a drop");
   aux_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
      auxBelow |=> !resetOut_n) else $error("reset missed an aux drop");
   release_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(resetOut_n) |-> goodCnt_reg >= SHORT_CYC) else $error("early supply release");
   manual_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(resetOut_n) |-> manHigh_reg >= MANUAL_CYC) else $error("early manual release");
   manual_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      manLow_reg >= 32'h1e |-> !resetOut_n) else $error("manual low not held");
   pf_assert_a: assert property (@(posedge clk) disable iff (!rst_n)
      powerfailBelow |=> !powerfail_flag_n) else $error("flag not asserted");
   pf_free_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(powerfailBelow) && resetOut_n |=> powerfail_flag_n) else $error("flag delayed");
   good_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
      primaryBelow |=> !primary_supply_good) else $error("good stayed high");
   good_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(primary_supply_good) |-> priCnt_reg >= GOOD_CYC) else $error("good too early");
   good_alone_a: assert property (@(posedge clk) disable iff (!rst_n)
      priCnt_reg >= GOOD_CYC + 6 |-> primary_supply_good) else $error("good not high");
   pin_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
      resetOut_n |-> !resetOe) else $error("pin driven while released");
endmodule

bind dual_supply_reset_supervisor supervisor_asserts #(
   .SHORT_CYC(SHORT_CYC), .MANUAL_CYC(MANUAL_CYC), .GOOD_CYC(GOOD_CYC)
) u_supervisor_asserts (
   .clk(clk), .rst_n(rst_n), .primaryBelow(primaryBelow),
   .secondaryBelow(secondaryBelow), .auxBelow(auxBelow),
   .powerfailBelow(powerfailBelow), .manual_reset_in_n(manual_reset_in_n),
   .resetOut_n(resetOut_n), .resetOe(resetOe), .powerfail_flag_n(powerfail_flag_n),
   .primary_supply_good(primary_supply_good)
);
